// >>> rtl/tmr16_pkg.sv
package tmr16_pkg;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;
	// register selects on the byte bus
	localparam logic [2:0] SEL_CTRL_FIRST = 3'h0;
	localparam logic [2:0] SEL_CTRL_SECOND = 3'h1;
	localparam logic [2:0] SEL_CNT_LO = 3'h2;
	localparam logic [2:0] SEL_CNT_HI = 3'h3;
	localparam logic [2:0] SEL_CMPA_LO = 3'h4;
	localparam logic [2:0] SEL_CMPA_HI = 3'h5;
	localparam logic [2:0] SEL_CAP_LO = 3'h6;
	localparam logic [2:0] SEL_CAP_HI = 3'h7;
	// field positions
	localparam int F1_MODE_LSB = 0;
	localparam int F2_CS_LSB = 0;
	localparam int F2_MODE_LSB = 3;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// counter limits and fixed tops
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	// clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [9:0] PRE_WRAP_8 = 10'h007;
	localparam logic [9:0] PRE_WRAP_64 = 10'h03f;
	localparam logic [9:0] PRE_WRAP_256 = 10'h0ff;
	localparam logic [9:0] PRE_WRAP_1024 = 10'h3ff;

	typedef enum logic [3:0] {
		SEQ_NORMAL = 4'b0001,
		SEQ_CLR_TOP = 4'b0010,
		SEQ_FAST = 4'b0100,
		SEQ_DUAL = 4'b1000
	} tmr16_seq_t;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} tmr16_dir_t;

	typedef struct packed {
		logic [2:0] sel;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tmr16_bus_t;
endpackage

// >>> rtl/tmr16_core.sv
`timescale 1ns/1ps
module tmr16_core import tmr16_pkg::*; #(
	parameter int WIDTH = CNT_W
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire tmr16_bus_t i_bus,
	input wire logic i_ext_clk,
	input wire logic i_ovf_clr,
	output logic [7:0] o_rdata,
	output logic [WIDTH-1:0] o_count,
	output logic o_top,
	output logic o_bottom,
	output logic o_overflow_flag
);
	logic [WIDTH-1:0] count;
	logic [7:0] hi_latch;
	logic [7:0] ctrl_first;
	logic [7:0] ctrl_second;
	logic [WIDTH-1:0] cmpa;
	logic [WIDTH-1:0] cap;
	logic [9:0] pre_cnt;
	logic ext_prev;
	logic timer_tick;
	logic [3:0] mode;
	logic [2:0] cs;
	logic [WIDTH-1:0] top_val;
	tmr16_seq_t seq;
	tmr16_dir_t dir;
	logic cpu_cnt_wr;

	// mode index 0..15 to count sequence class
	function automatic tmr16_seq_t seq_of(input logic [3:0] m);
		unique case (m)
			4'h4, 4'hc: seq_of = SEQ_CLR_TOP;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: seq_of = SEQ_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: seq_of = SEQ_DUAL;
			default: seq_of = SEQ_NORMAL; // modes 0 and reserved 13
		endcase
	endfunction

	// mode index to top value
	function automatic logic [WIDTH-1:0] top_of(input logic [3:0] m, input logic [WIDTH-1:0] a,
		input logic [WIDTH-1:0] c);
		unique case (m)
			4'h1, 4'h5: top_of = WIDTH'(TOP_8BIT);
			4'h2, 4'h6: top_of = WIDTH'(TOP_9BIT);
			4'h3, 4'h7: top_of = WIDTH'(TOP_10BIT);
			4'h4, 4'h9, 4'hb, 4'hf: top_of = a;
			4'h8, 4'ha, 4'hc, 4'he: top_of = c;
			default: top_of = WIDTH'(CNT_MAX);
		endcase
	endfunction

	// mode bits split over both controls
	assign mode = {ctrl_second[F2_MODE_LSB+1:F2_MODE_LSB], ctrl_first[F1_MODE_LSB+1:F1_MODE_LSB]};
	assign cs = ctrl_second[F2_CS_LSB+2:F2_CS_LSB];
	assign seq = seq_of(mode);
	assign top_val = top_of(mode, cmpa, cap);
	assign cpu_cnt_wr = i_bus.wr && i_bus.sel == SEL_CNT_LO;

	// prescaler is held at zero with no source, so restart is aligned
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			pre_cnt <= 10'h000;
			ext_prev <= 1'b0;
		end else begin
			pre_cnt <= (cs == CS_STOP) ? 10'h000 : pre_cnt + 10'h001;
			ext_prev <= i_ext_clk;
		end
	end

	// tick source; no tick at all when select is zero
	always_comb begin
		unique case (cs)
			CS_STOP: timer_tick = 1'b0;
			CS_DIV1: timer_tick = 1'b1;
			CS_DIV8: timer_tick = (pre_cnt[2:0] == PRE_WRAP_8[2:0]);
			CS_DIV64: timer_tick = (pre_cnt[5:0] == PRE_WRAP_64[5:0]);
			CS_DIV256: timer_tick = (pre_cnt[7:0] == PRE_WRAP_256[7:0]);
			CS_DIV1024: timer_tick = (pre_cnt == PRE_WRAP_1024);
			CS_EXT_FALL: timer_tick = ext_prev && !i_ext_clk;
			default: timer_tick = !ext_prev && i_ext_clk; // rising edge
		endcase
	end

	// control registers, plain byte writes
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_first <= RST_BYTE;
			ctrl_second <= RST_BYTE;
		end else if (i_bus.wr && i_bus.sel == SEL_CTRL_FIRST) begin
			ctrl_first <= i_bus.wdata;
		end else if (i_bus.wr && i_bus.sel == SEL_CTRL_SECOND) begin
			ctrl_second <= i_bus.wdata;
		end
	end

	// one latch shared by all wide registers; it only changes on its own triggers
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			hi_latch <= RST_BYTE;
		end else if (i_bus.wr && (i_bus.sel == SEL_CNT_HI || i_bus.sel == SEL_CMPA_HI
			|| i_bus.sel == SEL_CAP_HI)) begin
			hi_latch <= i_bus.wdata;
		end else if (i_bus.rd && i_bus.sel == SEL_CNT_LO) begin
			hi_latch <= count[15:8];
		end else if (i_bus.rd && i_bus.sel == SEL_CAP_LO) begin
			hi_latch <= cap[15:8];
		end
	end // held otherwise

	// compare and capture words, loaded through the latch on low write
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			cmpa <= RST_WORD;
			cap <= RST_WORD;
		end else if (i_bus.wr && i_bus.sel == SEL_CMPA_LO) begin
			cmpa <= {hi_latch, i_bus.wdata};
		end else if (i_bus.wr && i_bus.sel == SEL_CAP_LO) begin
			cap <= {hi_latch, i_bus.wdata};
		end
	end

	// counter: cpu write first, then the tick action of the mode
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			count <= RST_WORD;
			dir <= DIR_UP;
		end else if (cpu_cnt_wr) begin
			count <= {hi_latch, i_bus.wdata};
		end else if (timer_tick) begin
			unique case (seq)
				SEQ_NORMAL: begin
					count <= count + WIDTH'(1);
					dir <= DIR_UP;
				end
				SEQ_CLR_TOP, SEQ_FAST: begin
					count <= (count == top_val) ? WIDTH'(CNT_BOTTOM) : count + WIDTH'(1);
					dir <= DIR_UP;
				end
				SEQ_DUAL: begin
					// turn at the ends; a top lowered below count also turns down
					if (dir == DIR_UP && count >= top_val) begin
						count <= count - WIDTH'(1);
						dir <= DIR_DOWN;
					end else if (dir == DIR_DOWN && count == CNT_BOTTOM) begin
						count <= count + WIDTH'(1);
						dir <= DIR_UP;
					end else if (dir == DIR_UP) begin
						count <= count + WIDTH'(1);
					end else begin
						count <= count - WIDTH'(1);
					end
				end
			endcase
		end
	end

	// overflow flag: set per mode, cleared by a clear pulse, set wins
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_overflow_flag <= 1'b0;
		end else if (timer_tick && !cpu_cnt_wr && (
			((seq == SEQ_NORMAL || seq == SEQ_CLR_TOP) && count == CNT_MAX) ||
			(seq == SEQ_FAST && count == top_val) ||
			(seq == SEQ_DUAL && count == CNT_BOTTOM && dir == DIR_DOWN))) begin
			o_overflow_flag <= 1'b1;
		end else if (i_ovf_clr) begin
			o_overflow_flag <= 1'b0;
		end
	end

	// read data registered; the upper count byte reads the latch
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= RST_BYTE;
		end else if (i_bus.rd) begin
			unique case (i_bus.sel)
				SEL_CTRL_FIRST: o_rdata <= ctrl_first;
				SEL_CTRL_SECOND: o_rdata <= ctrl_second;
				SEL_CNT_LO: o_rdata <= count[7:0];
				SEL_CNT_HI: o_rdata <= hi_latch;
				SEL_CMPA_LO: o_rdata <= cmpa[7:0];
				SEL_CMPA_HI: o_rdata <= cmpa[15:8]; // compare read bypasses latch
				SEL_CAP_LO: o_rdata <= cap[7:0];
				SEL_CAP_HI: o_rdata <= hi_latch;
			endcase
		end
	end

	assign o_count = count;
	assign o_bottom = (count == CNT_BOTTOM);
	assign o_top = (count == top_val);

	// checks
	sequence s_lo_read;
		i_bus.rd && i_bus.sel == SEL_CNT_LO;
	endsequence
	sequence s_hi_read;
		i_bus.rd && i_bus.sel == SEL_CNT_HI && !i_bus.wr;
	endsequence

	a_stop_holds: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		cs == CS_STOP && !cpu_cnt_wr |=> $stable(count)) else $error("counter moved with no tick");
	a_write_wins: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		cpu_cnt_wr |=> count == {$past(hi_latch), $past(i_bus.wdata)}) else $error("cpu write lost");
	a_read_pair: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(s_lo_read ##1 s_hi_read) |=> o_rdata == $past(count[15:8], 2)) else $error("upper byte not latched");
	a_normal_step: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		timer_tick && !cpu_cnt_wr && seq == SEQ_NORMAL |=> count == $past(count) + WIDTH'(1))
		else $error("normal step wrong");
	a_ctc_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		timer_tick && !cpu_cnt_wr && seq == SEQ_CLR_TOP && count == top_val |=> count == CNT_BOTTOM)
		else $error("no clear at top");
	a_ovf_max: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		timer_tick && !cpu_cnt_wr && seq == SEQ_NORMAL && count == CNT_MAX |=> o_overflow_flag && count == 0)
		else $error("overflow not set at max");
	a_ovf_sticky: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		o_overflow_flag && !i_ovf_clr |=> o_overflow_flag) else $error("flag dropped");
	a_latch_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!i_bus.wr && !i_bus.rd |=> $stable(hi_latch)) else $error("latch changed");
	a_top_fixed: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		mode == 4'h1 || mode == 4'h5 |-> top_val == WIDTH'(TOP_8BIT)) else $error("fixed top wrong");
	a_dual_turn: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		timer_tick && !cpu_cnt_wr && seq == SEQ_DUAL && dir == DIR_DOWN && count == 0
		|=> dir == DIR_UP && count == 1) else $error("no turn at bottom");
endmodule

// >>> dv/tmr16_cpu_model.sv
`timescale 1ns/1ps
// cpu side of the byte bus; each access goes out whole and in order
module tmr16_cpu_model import tmr16_pkg::*; (
	input wire logic i_mclk,
	output tmr16_bus_t o_bus
);
	initial o_bus = '0;
	// one byte access, held up to the edge that takes it
	task automatic access(input logic [2:0] sel, input logic wr, input logic [7:0] d);
		o_bus = '{sel: sel, wr: wr, rd: ~wr, wdata: d};
		@(posedge i_mclk);
		#1;
	endtask
	// released data lines flip, so a stale byte never passes for a good one
	task automatic idle();
		o_bus = '{sel: o_bus.sel, wr: 1'b0, rd: 1'b0, wdata: ~o_bus.wdata};
		@(posedge i_mclk);
		#1;
	endtask
	// two-byte read, low first and never split by another access
	task automatic rd16(input logic [2:0] sel_lo);
		access(sel_lo, 1'b0, 8'h00);
		access(sel_lo + 3'h1, 1'b0, 8'h00);
		idle();
	endtask
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", nm, e, a); end end
module testbench import tmr16_pkg::*;;
	logic i_mclk, i_nrst, i_ext_clk, i_ovf_clr, rd_seen, o_top, o_bottom, o_overflow_flag;
	tmr16_bus_t bus;
	logic [7:0] o_rdata, exp_b;
	logic [15:0] o_count, v;
	logic [7:0] exp_q[$];
	int failures, cmp_count, cyc_n;
	tmr16_core i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(bus), .i_ext_clk(i_ext_clk), .i_ovf_clr(i_ovf_clr),
		.o_rdata(o_rdata), .o_count(o_count), .o_top(o_top), .o_bottom(o_bottom), .o_overflow_flag(o_overflow_flag));
	tmr16_cpu_model i_cpu (.i_mclk(i_mclk), .o_bus(bus));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// read data lands on the same edge that takes the read
	always @(posedge i_mclk) rd_seen <= bus.rd;
	always @(negedge i_mclk) begin
		if (rd_seen === 1'b1) begin
			exp_b = exp_q.pop_front();
			`CHK("rdata", exp_b, o_rdata)
		end
	end
	// hang guard, far above the roughly two hundred cycles the tests need
	always @(posedge i_mclk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			failures++;
			end_of_test();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// high byte first; the low byte write must land whole even while counting
	task automatic w16(input logic [2:0] sel_lo, input logic [15:0] val);
		i_cpu.access(sel_lo + 3'h1, 1'b1, val[15:8]);
		i_cpu.access(sel_lo, 1'b1, val[7:0]);
		if (sel_lo == SEL_CNT_LO) `CHK("count", val, o_count)
		i_cpu.idle();
	endtask
	task automatic r16(input logic [2:0] sel_lo, input logic [15:0] val);
		exp_q.push_back(val[7:0]);
		exp_q.push_back(val[15:8]);
		i_cpu.rd16(sel_lo);
	endtask
	task automatic ctrl(input logic [7:0] f, input logic [7:0] s);
		i_cpu.access(SEL_CTRL_FIRST, 1'b1, f);
		i_cpu.access(SEL_CTRL_SECOND, 1'b1, s);
		i_cpu.idle();
	endtask
	// each tick moves one step; fast mode wraps to zero after top
	task automatic steps(input int n, input logic [15:0] top, input logic fast);
		logic [15:0] p;
		for (int i = 0; i < n; i++) begin
			p = o_count;
			cyc(1);
			`CHK("top", o_count == top, o_top)
			`CHK("bottom", o_count == 16'h0000, o_bottom)
			if (fast) `CHK("clear", (p == top) ? 16'h0000 : p + 16'h0001, o_count)
			else `CHK("step", 1'b1, o_count == p + 16'h0001 || o_count == p - 16'h0001)
		end
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		i_nrst = 1'b0;
		i_ext_clk = 1'b0;
		i_ovf_clr = 1'b0;
		void'($urandom(32'h6d90d7ef));
		cyc(2);
		i_nrst = 1'b1;
		`CHK("count", 16'h0000, o_count)
		`CHK("bottom", 1'b1, o_bottom)
		`CHK("flag", 1'b0, o_overflow_flag)
		r16(SEL_CNT_LO, 16'h0000);
		done("reset");
		w16(SEL_CNT_LO, 16'h01ff);
		cyc(5);
		`CHK("held", 16'h01ff, o_count)
		r16(SEL_CNT_LO, 16'h01ff);
		done("stopped");
		// latch loaded once serves a second wide register
		w16(SEL_CNT_LO, 16'h1234);
		i_cpu.access(SEL_CMPA_LO, 1'b1, 8'h56);
		i_cpu.idle();
		r16(SEL_CMPA_LO, 16'h1256);
		done("latch");
		w16(SEL_CNT_LO, 16'hfffd);
		i_ovf_clr = 1'b1;
		cyc(1);
		i_ovf_clr = 1'b0;
		ctrl(8'h00, {5'h00, CS_DIV1});
		cyc(4);
		ctrl(8'h00, {5'h00, CS_STOP});
		`CHK("ovf", 1'b1, o_overflow_flag)
		`CHK("wrap", 16'h0004, o_count)
		i_ovf_clr = 1'b1;
		cyc(1);
		i_ovf_clr = 1'b0;
		`CHK("ovf", 1'b0, o_overflow_flag)
		done("overflow");
		w16(SEL_CNT_LO, 16'h00fc);
		ctrl(8'h01, {5'h00, CS_DIV1});
		steps(8, TOP_8BIT, 1'b0);
		// a write while counting down keeps the direction; the turn at bottom sets the flag
		w16(SEL_CNT_LO, 16'h0003);
		steps(4, TOP_8BIT, 1'b0);
		ctrl(8'h00, {5'h00, CS_STOP});
		`CHK("ovf", 1'b1, o_overflow_flag)
		done("updown");
		w16(SEL_CNT_LO, 16'h00fd);
		ctrl(8'h01, {5'h01, CS_DIV1});
		steps(6, TOP_8BIT, 1'b1);
		v = 16'($urandom);
		w16(SEL_CNT_LO, v);
		ctrl(8'h00, {5'h00, CS_STOP});
		done("fast");
		// clear at top, with the compare word as top
		w16(SEL_CMPA_LO, 16'h0105);
		w16(SEL_CNT_LO, 16'h0102);
		ctrl(8'h00, {5'h01, CS_DIV1});
		steps(6, 16'h0105, 1'b1);
		ctrl(8'h00, {5'h00, CS_STOP});
		done("clear at top");
		// external edges, each level held three cycles so every edge is seen once
		w16(SEL_CNT_LO, 16'h0100);
		ctrl(8'h00, {5'h00, CS_EXT_FALL});
		repeat (4) begin
			i_ext_clk = 1'b1;
			cyc(3);
			i_ext_clk = 1'b0;
			cyc(3);
		end
		cyc(3);
		ctrl(8'h00, {5'h00, CS_STOP});
		`CHK("ext", 16'h0104, o_count)
		// select 7 counts rising edges instead
		ctrl(8'h00, {5'h00, 3'h7});
		repeat (2) begin
			i_ext_clk = 1'b1;
			cyc(3);
			i_ext_clk = 1'b0;
			cyc(3);
		end
		ctrl(8'h00, {5'h00, CS_STOP});
		`CHK("ext rise", 16'h0106, o_count)
		done("external");
		// prescaled ticks every eighth cycle, then a reset in mid-run while counting
		w16(SEL_CNT_LO, 16'h0110);
		ctrl(8'h00, {5'h00, CS_DIV8});
		cyc(28);
		`CHK("div8", 16'h0113, o_count)
		i_nrst = 1'b0;
		cyc(1);
		i_nrst = 1'b1;
		`CHK("count", 16'h0000, o_count)
		`CHK("flag", 1'b0, o_overflow_flag)
		exp_q.push_back(8'h00);
		i_cpu.access(SEL_CNT_HI, 1'b0, 8'h00);
		r16(SEL_CMPA_LO, 16'h0000);
		done("prescale and reset");
		end_of_test();
	end
endmodule
